// ---- logic/gcss_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gcss_params.svh"

// Overview of operation
// R1: second general select base comes from address bits 18 down to 11.
// R2: a four-bit size field in the control register sets region extent.
// R3: polarity bit 0 makes the second general pin active low, 1 active high.
// R4: window bit 0 asserts only while bus clock high; 1 whole address time.
// R5: drive-program bit ORs second general decode onto the program pin.
// R6: when second general drives program pin, its own pin never asserts.
// R7: first general routed to program pin: its pin never asserts.
// R8: first-to-second routing merges general 1 onto second pin, unless program routed.
// R9: chip selects and bus control change in step with the bus clock.
// R10: stretching holds bus clock high one to three extra bus cycles.
// R11: stretch applies only to accesses inside that select's region.
// R12: internal timer and baud ticks keep running during a stretch.
// R13: each select has a two-bit stretch field; zero disables stretching.
// R14: an unasserted select pin rests at the inactive level of its polarity.
module gcss_top #(
  parameter int E_HALF = `GCSS_E_PERIOD_NS / (2 * `GCSS_CLK_NS)
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [18:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        prog_region_hit,
  input  wire logic        gen1_region_hit,
  output logic             e_clk,
  output logic             cycle_start,
  output logic             bus_tick,
  output logic             program_select_pin,
  output logic             gen1_select_pin,
  output logic             general_select_two_pin
);

  localparam logic [7:0] HALF_MAX = 8'(E_HALF - 1);
  localparam logic [8:0] TICK_MAX = 9'(2 * E_HALF - 1);

  logic rst_meta;
  logic rst_n_sync;

  gcss_pkg::gcss_state_t s;
  gcss_pkg::gcss_state_t n;

  logic [1:0] st_amt;
  logic       prog_act;
  logic       g1_act;
  logic       g2_act;
  logic       g2_window;

  function automatic logic region_hit(input logic [18:0] a,
                                      input logic [7:0]  base,
                                      input logic [3:0]  sz);
    logic [3:0] lim;
    logic [7:0] m;
    lim = (sz > `GCSS_MAX_SIZE) ? `GCSS_MAX_SIZE : sz;
    // size n spans 2k << (n-1), sizes above 8 acting as size 8; size 0 disables the select
    m = 8'hff << (lim - 4'h1);
    region_hit = (sz != 4'h0) && ((a[18:11] & m) == (base & m)); // R1 R2
  endfunction

  function automatic logic pin_level(input logic act, input logic pol);
    pin_level = pol ? act : ~act; // R3 R14
  endfunction

  function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  always_comb begin
    n = s;
    n.cycle_start = 1'b0;
    n.bus_tick    = 1'b0;
    n.rd_data     = 8'h00;
    st_amt        = 2'h0;

    if (reg_wr) begin
      case (reg_addr)
        `GCSS_OFS_BASE:    n.base_reg = reg_wdata;
        `GCSS_OFS_CONTROL: n.ctrl_reg = reg_wdata;
        `GCSS_OFS_AUX:     n.aux_reg  = reg_wdata[3:0];
        `GCSS_OFS_STRETCH: n.strc_reg = reg_wdata[5:0];
        default:           n.base_reg = s.base_reg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `GCSS_OFS_BASE:    n.rd_data = s.base_reg;
        `GCSS_OFS_CONTROL: n.rd_data = s.ctrl_reg;
        `GCSS_OFS_AUX:     n.rd_data = {4'h0, s.aux_reg};
        `GCSS_OFS_STRETCH: n.rd_data = {2'h0, s.strc_reg};
        `GCSS_OFS_STATUS:  n.rd_data = {3'h0, s.prog_pin, s.g1_pin, s.g2_pin,
                                        (s.stretch_halves != 3'h0), s.e_high};
        default:           n.rd_data = 8'h00;
      endcase
    end

    // free-running tick for timers and baud generators, blind to stretching
    if (s.tick_cnt == TICK_MAX) begin
      n.tick_cnt = 9'h000;
      n.bus_tick = 1'b1; // R12
    end else begin
      n.tick_cnt = s.tick_cnt + 9'h001;
    end

    // stretch is the largest setting among selects the address decodes to
    if (s.prog_hit) begin
      st_amt = max2(st_amt, s.strc_reg[`GCSS_STR_PROG +: 2]); // R11 R13
    end
    if (s.g1_hit) begin
      st_amt = max2(st_amt, s.strc_reg[`GCSS_STR_G1 +: 2]); // R11 R13
    end
    if (s.g2_hit) begin
      st_amt = max2(st_amt, s.strc_reg[`GCSS_STR_G2 +: 2]); // R11 R13
    end

    if (s.ph_cnt == HALF_MAX) begin
      n.ph_cnt = 8'h00;
      if (!s.e_high) begin
        n.e_high         = 1'b1;
        n.stretch_halves = {st_amt, 1'b0}; // R10
      end else if (s.stretch_halves != 3'h0) begin
        n.stretch_halves = s.stretch_halves - 3'h1; // R10
      end else begin
        // address is taken only at the falling bus clock edge
        n.e_high      = 1'b0; // R9
        n.cycle_start = 1'b1;
        n.addr        = cpu_addr;
        n.addr_ok     = cpu_addr_valid;
        n.prog_hit    = cpu_addr_valid & prog_region_hit;
        n.g1_hit      = cpu_addr_valid & gen1_region_hit;
      end
    end else begin
      n.ph_cnt = s.ph_cnt + 8'h01;
    end

    // decode against the next register values so pins follow writes at once
    n.g2_hit = n.addr_ok & region_hit(n.addr, n.base_reg,
                                      n.ctrl_reg[`GCSS_CTL_SIZE_HI:`GCSS_CTL_SIZE_LO]);

    prog_act = n.prog_hit
             | (n.aux_reg[`GCSS_AUX_G1_PROG] & n.g1_hit)   // R7
             | (n.ctrl_reg[`GCSS_CTL_TO_PROG] & n.g2_hit); // R5
    g2_act = ~n.ctrl_reg[`GCSS_CTL_TO_PROG]                // R6
           & (n.g2_hit | (n.aux_reg[`GCSS_AUX_G1_G2]
                        & ~n.aux_reg[`GCSS_AUX_G1_PROG] & n.g1_hit)); // R8
    g1_act = n.g1_hit
           & ~n.aux_reg[`GCSS_AUX_G1_PROG]                 // R7
           & ~(n.aux_reg[`GCSS_AUX_G1_G2] & ~n.ctrl_reg[`GCSS_CTL_TO_PROG]); // R8
    g2_window = n.ctrl_reg[`GCSS_CTL_VALID] | n.e_high;    // R4

    n.prog_pin = pin_level(prog_act, n.aux_reg[`GCSS_AUX_PROG_POL]);
    n.g1_pin   = pin_level(g1_act, n.aux_reg[`GCSS_AUX_G1_POL]);
    n.g2_pin   = pin_level(g2_act & g2_window, n.ctrl_reg[`GCSS_CTL_POL]); // R3 R4
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s                <= '0;
      s.base_reg       <= `GCSS_RST_BASE;
      s.ctrl_reg       <= `GCSS_RST_CONTROL;
      s.aux_reg        <= `GCSS_RST_AUX;
      s.strc_reg       <= `GCSS_RST_STRETCH;
      // all selects reset active low, so they rest high
      s.prog_pin       <= 1'b1; // R14
      s.g1_pin         <= 1'b1;
      s.g2_pin         <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata              = s.rd_data;
  assign e_clk                  = s.e_high;
  assign cycle_start            = s.cycle_start;
  assign bus_tick               = s.bus_tick;
  assign program_select_pin     = s.prog_pin;
  assign gen1_select_pin        = s.g1_pin;
  assign general_select_two_pin = s.g2_pin;

  // helper counters read only by the checks below
  logic [1:0]  chk_st;
  logic [11:0] chk_high_len;
  logic [9:0]  chk_tick_gap;
  logic        chk_ticked;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      chk_st       <= 2'h0;
      chk_high_len <= 12'h000;
      chk_tick_gap <= 10'h000;
      chk_ticked   <= 1'b0;
    end else begin
      if (!s.e_high && n.e_high) begin
        chk_st <= st_amt;
      end
      chk_high_len <= s.e_high ? chk_high_len + 12'h001 : 12'h000;
      chk_tick_gap <= s.bus_tick ? 10'h000 : chk_tick_gap + 10'h001;
      if (s.bus_tick) begin
        chk_ticked <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_sync);

  sel2_active_decode_a: assert property ( // R2 R8
    (general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL])
      |-> s.g2_hit
        || (s.aux_reg[`GCSS_AUX_G1_G2] && !s.aux_reg[`GCSS_AUX_G1_PROG] && s.g1_hit)
  ) else $error("second general pin active outside its region");

  sel2_e_window_a: assert property ( // R4
    (!s.ctrl_reg[`GCSS_CTL_VALID]
      && general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL]) |-> e_clk
  ) else $error("second general pin active with bus clock low");

  prog_or_sel2_a: assert property ( // R5
    (s.ctrl_reg[`GCSS_CTL_TO_PROG] && s.g2_hit)
      |-> program_select_pin == s.aux_reg[`GCSS_AUX_PROG_POL]
  ) else $error("program pin missed a routed second general hit");

  sel2_never_a: assert property ( // R6
    s.ctrl_reg[`GCSS_CTL_TO_PROG]
      |-> general_select_two_pin == ~s.ctrl_reg[`GCSS_CTL_POL]
  ) else $error("second general pin asserted while routed to program");

  sel1_never_a: assert property ( // R7
    s.aux_reg[`GCSS_AUX_G1_PROG] |-> gen1_select_pin == ~s.aux_reg[`GCSS_AUX_G1_POL]
  ) else $error("first general pin asserted while routed to program");

  sel1_into_two_a: assert property ( // R8
    (s.aux_reg[`GCSS_AUX_G1_G2] && !s.aux_reg[`GCSS_AUX_G1_PROG]
      && !s.ctrl_reg[`GCSS_CTL_TO_PROG] && s.g1_hit
      && (s.ctrl_reg[`GCSS_CTL_VALID] || e_clk))
      |-> general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL]
        && gen1_select_pin == ~s.aux_reg[`GCSS_AUX_G1_POL]
  ) else $error("first general hit not merged onto second pin");

  cycle_sync_a: assert property ( // R9
    cycle_start |-> $fell(e_clk) ##1 !cycle_start
  ) else $error("cycle start not aligned with falling bus clock");

  stretch_length_a: assert property ( // R10
    $fell(e_clk) |-> chk_high_len == 12'((1 + 2 * chk_st) * E_HALF)
  ) else $error("bus clock high time does not match stretch setting");

  tick_steady_a: assert property ( // R12
    (bus_tick && chk_ticked) |-> chk_tick_gap == 10'(2 * E_HALF - 1)
  ) else $error("internal tick disturbed");

  idle_level_a: assert property ( // R14
    !s.addr_ok |-> program_select_pin == ~s.aux_reg[`GCSS_AUX_PROG_POL]
      && gen1_select_pin == ~s.aux_reg[`GCSS_AUX_G1_POL]
      && general_select_two_pin == ~s.ctrl_reg[`GCSS_CTL_POL]
  ) else $error("select pin active with no valid address");

  sel2_base_match_a: assert property ( // R1
    (s.addr_ok && s.addr[18:11] == s.base_reg
      && s.ctrl_reg[`GCSS_CTL_SIZE_HI:`GCSS_CTL_SIZE_LO] != 4'h0) |-> s.g2_hit
  ) else $error("address at the second general base missed its region");

  sel2_size_off_a: assert property ( // R2
    (s.ctrl_reg[`GCSS_CTL_SIZE_HI:`GCSS_CTL_SIZE_LO] == 4'h0) |-> !s.g2_hit
  ) else $error("second general region decoded with size zero");

  sel2_level_a: assert property ( // R3
    (s.g2_hit && s.ctrl_reg[`GCSS_CTL_VALID] && !s.ctrl_reg[`GCSS_CTL_TO_PROG])
      |-> general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL]
  ) else $error("second general pin not at its active level");

  sel2_e_high_a: assert property ( // R4
    (s.g2_hit && !s.ctrl_reg[`GCSS_CTL_VALID] && !s.ctrl_reg[`GCSS_CTL_TO_PROG] && e_clk)
      |-> general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL]
  ) else $error("second general pin idle during bus clock high");

  prog_own_hit_a: assert property ( // R5
    s.prog_hit |-> program_select_pin == s.aux_reg[`GCSS_AUX_PROG_POL]
  ) else $error("program pin missed a program address");

  sel1_to_prog_a: assert property ( // R7
    (s.aux_reg[`GCSS_AUX_G1_PROG] && s.g1_hit)
      |-> program_select_pin == s.aux_reg[`GCSS_AUX_PROG_POL]
  ) else $error("program pin missed a routed first general hit");

  sel1_direct_a: assert property ( // R8
    (s.g1_hit && !s.aux_reg[`GCSS_AUX_G1_PROG]
      && (!s.aux_reg[`GCSS_AUX_G1_G2] || s.ctrl_reg[`GCSS_CTL_TO_PROG]))
      |-> gen1_select_pin == s.aux_reg[`GCSS_AUX_G1_POL]
  ) else $error("first general pin missed its own address");

  addr_hold_a: assert property ( // R9
    !cycle_start |-> $stable(s.addr) && $stable(s.addr_ok)
  ) else $error("bus address moved inside a bus cycle");

  stretch_hold_a: assert property ( // R10
    (e_clk && s.stretch_halves != 3'h0) |=> e_clk
  ) else $error("bus clock dropped while stretch remained");

  // hits and fields taken a cycle back: a write landing on the rising
  // edge changes the registers after the stretch amount was chosen
  stretch_region_a: assert property ( // R11
    ($rose(e_clk) && !$past(s.prog_hit) && !$past(s.g1_hit) && !$past(s.g2_hit))
      |-> s.stretch_halves == 3'h0
  ) else $error("bus clock stretched outside any select region");

  stretch_field_a: assert property ( // R13
    ($rose(e_clk) && $past(s.g2_hit) && !$past(s.prog_hit) && !$past(s.g1_hit))
      |-> s.stretch_halves == {$past(s.strc_reg[`GCSS_STR_G2 +: 2]), 1'b0}
  ) else $error("bus clock stretch does not follow the second general field");

  tick_in_stretch_a: assert property ( // R12
    (e_clk && s.stretch_halves != 3'h0 && chk_ticked) |-> chk_tick_gap < 10'(2 * E_HALF)
  ) else $error("internal tick stalled during a stretch");

  stretch_three_c: cover property ($fell(e_clk) && chk_st == 2'h3);
  stretch_prog_c: cover property ($rose(e_clk) && s.prog_hit && s.stretch_halves != 3'h0);
  all_to_prog_c: cover property (s.aux_reg[`GCSS_AUX_G1_PROG]
    && s.ctrl_reg[`GCSS_CTL_TO_PROG] && s.g1_hit && s.g2_hit);
  sel2_high_c: cover property (s.ctrl_reg[`GCSS_CTL_POL] && general_select_two_pin);
  merge_c: cover property (s.aux_reg[`GCSS_AUX_G1_G2] && s.g1_hit
    && general_select_two_pin == s.ctrl_reg[`GCSS_CTL_POL]);

endmodule

`default_nettype wire

// ---- logic/gcss_params.svh ----
`ifndef GCSS_PARAMS_SVH
`define GCSS_PARAMS_SVH

// register offsets
`define GCSS_OFS_STATUS   8'h5b
`define GCSS_OFS_STRETCH  8'h5c
`define GCSS_OFS_AUX      8'h5d
`define GCSS_OFS_BASE     8'h5e
`define GCSS_OFS_CONTROL  8'h5f

// control register fields
`define GCSS_CTL_POL      7
`define GCSS_CTL_VALID    6
`define GCSS_CTL_TO_PROG  5
`define GCSS_CTL_SIZE_HI  3
`define GCSS_CTL_SIZE_LO  0

// auxiliary routing register fields
`define GCSS_AUX_G1_PROG  0
`define GCSS_AUX_G1_G2    1
`define GCSS_AUX_G1_POL   2
`define GCSS_AUX_PROG_POL 3

// stretch register fields, two bits each
`define GCSS_STR_PROG     0
`define GCSS_STR_G1       2
`define GCSS_STR_G2       4

// reset values
`define GCSS_RST_BASE     8'h00
`define GCSS_RST_CONTROL  8'h00
`define GCSS_RST_AUX      4'h0
`define GCSS_RST_STRETCH  6'h00

// timing
`define GCSS_CLK_NS       5
`define GCSS_E_PERIOD_NS  250
`define GCSS_MAX_SIZE     4'h8

`endif

// ---- logic/gcss_pkg.sv ----
package gcss_pkg;

  typedef struct packed {
    logic [7:0]  base_reg;
    logic [7:0]  ctrl_reg;
    logic [3:0]  aux_reg;
    logic [5:0]  strc_reg;
    logic [7:0]  ph_cnt;
    logic [8:0]  tick_cnt;
    logic        e_high;
    logic [2:0]  stretch_halves;
    logic [18:0] addr;
    logic        addr_ok;
    logic        prog_hit;
    logic        g1_hit;
    logic        g2_hit;
    logic        cycle_start;
    logic        bus_tick;
    logic        prog_pin;
    logic        g1_pin;
    logic        g2_pin;
    logic [7:0]  rd_data;
  } gcss_state_t;

endpackage

// ---- dv/gcss_bus_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side device: snapshots the select pins late in each bus clock half
module gcss_bus_device (
  input  wire logic       ref_clk,
  input  wire logic       e_clk,
  input  wire logic [2:0] pins,
  output logic            rep_v,
  output logic      [2:0] rep_lo,
  output logic      [2:0] rep_hi,
  output logic      [7:0] rep_len
);
  logic       e_q;
  logic [2:0] lo_c;
  logic [2:0] hi_c;
  logic [7:0] cnt = 8'h00;
  always @(posedge ref_clk) begin
    e_q <= e_clk;
    rep_v <= e_q & ~e_clk;
    if (e_q & ~e_clk) begin
      rep_lo <= lo_c;
      rep_hi <= hi_c;
      rep_len <= cnt;
    end
    if (e_clk) begin
      hi_c <= pins;
      cnt <= cnt + 8'h01;
    end else begin
      // last low sample is taken before the rising edge lands
      lo_c <= pins;
      cnt <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int EH = 3;
  typedef struct packed {logic [2:0] lo; logic [2:0] hi; logic [7:0] len;} gcss_exp_t;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [18:0] cpu_addr = 19'h0;
  logic        cpu_addr_valid = 1'b0;
  logic        prog_region_hit = 1'b0;
  logic        gen1_region_hit = 1'b0;
  logic        e_clk, cycle_start, bus_tick;
  logic        program_select_pin, gen1_select_pin, general_select_two_pin;
  logic        rep_v;
  logic [2:0]  rep_lo, rep_hi;
  logic [7:0]  rep_len;
  int          fail_count = 0;
  int          check_count = 0;
  int          tk = 0;
  logic        tk_on = 1'b0;
  logic        rd_q = 1'b0;
  logic        e_prev = 1'b0;
  logic [7:0]  ctl = 8'h00;
  logic [7:0]  base = 8'h00;
  logic [7:0]  aux = 8'h00;
  logic [7:0]  strc, r;
  gcss_exp_t   ex;
  gcss_exp_t   eq[$];
  logic [7:0]  rq[$];

  always #2.5 ref_clk = ~ref_clk;

  gcss_top #(.E_HALF(EH)) i_dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cpu_addr, .cpu_addr_valid, .prog_region_hit, .gen1_region_hit,
    .e_clk, .cycle_start, .bus_tick, .program_select_pin, .gen1_select_pin,
    .general_select_two_pin);
  gcss_bus_device i_dev (.ref_clk, .e_clk, .rep_v, .rep_lo, .rep_hi, .rep_len,
    .pins({program_select_pin, gen1_select_pin, general_select_two_pin}));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task end_of_test;
    if (eq.size() > 0 || rq.size() > 0)
      fail_count++;
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic g2dec(input logic [18:0] a);
    logic [7:0] m;
    m = 8'hff << ((ctl[3:0] > 4'h8 ? 4'h8 : ctl[3:0]) - 4'h1);
    return ctl[3:0] != 4'h0 && ((a[18:11] ^ base) & m) == 8'h00;
  endfunction

  function automatic logic [2:0] exp_pins(input logic g2, g1, pr, eh);
    logic pa, ga, ta;
    pa = pr | aux[0] & g1 | ctl[5] & g2;
    ta = ~ctl[5] & (g2 | aux[1] & ~aux[0] & g1) & (ctl[6] | eh);
    ga = g1 & ~aux[0] & ~(aux[1] & ~ctl[5]);
    return {pa ~^ aux[3], ga ~^ aux[2], ta ~^ ctl[7]};
  endfunction

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_cs;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (cycle_start !== 1'b1 && k < 100);
    if (k >= 100) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // waits a whole bus cycle so its report lands after the note is queued
  task automatic acc(input logic [18:0] a, input logic v, ph, g1, input logic [1:0] n);
    gcss_exp_t x;
    logic g2;
    g2 = v & g2dec(a);
    x.lo = exp_pins(g2, v & g1, v & ph, 1'b0);
    x.hi = exp_pins(g2, v & g1, v & ph, 1'b1);
    x.len = 8'((1 + 2 * n) * EH);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_addr_valid <= v;
    prog_region_hit <= ph;
    gen1_region_hit <= g1;
    wait_cs();
    wait_cs();
    eq.push_back(x);
  endtask

  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    e_prev <= e_clk;
    if (rd_q)
      chk(reg_rdata, rq.pop_front());
    if (nrst)
      chk(8'(cycle_start), 8'(e_prev & ~e_clk));
    if (rep_v === 1'b1 && eq.size() > 0) begin
      ex = eq.pop_front();
      chk(8'(rep_lo), 8'(ex.lo));
      chk(8'(rep_hi), 8'(ex.hi));
      chk(rep_len, ex.len);
    end
    if (bus_tick === 1'b1) begin
      if (tk_on)
        chk(8'(tk), 8'(2 * EH));
      tk_on = 1'b1;
      tk = 1;
    end else
      tk++;
    if (!nrst)
      tk_on = 1'b0;
  end

  initial begin
    r = 8'h60;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h5b, 8'h1c);
    rd(8'h5f, 8'h00);
    rd(8'h5e, 8'h00);
    rd(8'h00, 8'h00);
    base = 8'h5a;
    ctl = 8'h93;
    wr(8'h5e, base);
    wr(8'h5f, ctl);
    rd(8'h5e, base);
    rd(8'h5f, ctl);
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      aux = {4'h0, r[2:1], i[1:0]};
      ctl = {r[0], i[3], i[2], 5'h03};
      wr(8'h5d, aux);
      wr(8'h5f, ctl);
      acc({base ^ (r[7] ? {6'h0, r[4:3]} : 8'h80), r[6:0], 4'h5}, i != 6, r[5], r[6], 2'd0);
    end
    for (int n = 0; n < 4; n++) begin
      strc = {2'b00, 2'(n), 2'b00, 2'(3 - n)};
      // top two bits are unmapped and must not stick
      wr(8'h5c, strc | 8'hc0);
      rd(8'h5c, strc);
      acc({base, 11'h123}, 1'b1, 1'b0, 1'b0, 2'(n));
      acc({~base, 11'h0}, 1'b1, 1'b1, 1'b0, 2'(3 - n));
      acc({~base, 11'h0}, 1'b1, 1'b0, 1'b0, 2'd0);
    end
    repeat (40) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h5b, 8'h1c);
    rd(8'h5c, 8'h00);
    rd(8'h5d, 8'h00);
    repeat (4) @(posedge ref_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
